/* File: logic/adceil_top.sv */
`timescale 1ns/10ps
module adceil_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic conv_enable_i,
  input wire logic soft_reset_i,
  input wire adceil_pkg::adceil_evt_t evt_i,
  input wire logic abort_done_i,
  input wire logic complete_flag_overrun_i,
  input wire adceil_pkg::adceil_bus_t bus_i,
  output logic [7:0] rdata_o,
  output logic conv_halt_o,
  output logic err_irq_o,
  output logic evt_irq_o
);
  import adceil_pkg::*;

  // Address match shared by the write decode and the read mux
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Error interrupt enable bits, one flop each
  logic illegal_access_err_enable_r;
  logic bad_command_err_enable_r;
  logic list_end_err_enable_r;
  logic trigger_err_enable_r;
  logic restart_request_err_enable_r;
  logic load_ready_err_enable_r;

  // Event interrupt enable bits
  logic abort_done_irq_enable_r;
  logic complete_flag_overrun_enable_r;

  // Error flag bits, severe ones first
  logic illegal_access_err_flag_r;
  logic bad_command_err_flag_r;
  logic list_end_err_flag_r;
  logic trigger_err_flag_r;
  logic restart_request_err_flag_r;
  logic load_ready_err_flag_r;

  // Register images as software sees them, with their next values
  wire [7:0] err_ie;
  logic [7:0] err_ie_nxt;
  wire [7:0] evt_ie;
  logic [7:0] evt_ie_nxt;
  wire [7:0] err_flag;
  logic [7:0] err_flag_nxt;
  logic [7:0] evt_stat_r;
  logic [7:0] evt_stat_nxt;

  // Next values of the registered outputs
  logic [7:0] rdata_nxt;
  logic halt_nxt;
  logic err_irq_nxt;
  logic evt_irq_nxt;

  // Error enable image; bits without a function read zero
  assign err_ie[BIT_IA] = illegal_access_err_enable_r;
  assign err_ie[BIT_CMD] = bad_command_err_enable_r;
  assign err_ie[BIT_EOL] = list_end_err_enable_r;
  assign err_ie[BIT_RSVD_HI] = 1'b0;
  assign err_ie[BIT_TRIG] = trigger_err_enable_r;
  assign err_ie[BIT_RSTAR] = restart_request_err_enable_r;
  assign err_ie[BIT_ALT_LIST_LOAD_READY] = load_ready_err_enable_r;
  assign err_ie[BIT_RSVD_LO] = 1'b0;

  // Event enable image
  assign evt_ie[BIT_SEQAD] = abort_done_irq_enable_r;
  assign evt_ie[BIT_OVR] = complete_flag_overrun_enable_r;
  assign evt_ie[BIT_OVR-1:0] = '0;

  // Error flag image
  assign err_flag[BIT_IA] = illegal_access_err_flag_r;
  assign err_flag[BIT_CMD] = bad_command_err_flag_r;
  assign err_flag[BIT_EOL] = list_end_err_flag_r;
  assign err_flag[BIT_RSVD_HI] = 1'b0;
  assign err_flag[BIT_TRIG] = trigger_err_flag_r;
  assign err_flag[BIT_RSTAR] = restart_request_err_flag_r;
  assign err_flag[BIT_ALT_LIST_LOAD_READY] = load_ready_err_flag_r;
  assign err_flag[BIT_RSVD_LO] = 1'b0;

  // Address decode for each mapped register
  wire hit_err_ie = addr_hit(bus_i.addr, OFS_ERR_IE);
  wire hit_evt_ie = addr_hit(bus_i.addr, OFS_EVT_IE);
  wire hit_err_flag = addr_hit(bus_i.addr, OFS_ERR_FLAG);
  wire hit_evt_stat = addr_hit(bus_i.addr, OFS_EVT_STAT);

  // Write selects; a read strobe never disturbs a register
  wire sel_err_ie = bus_i.wr && hit_err_ie;
  wire sel_evt_ie = bus_i.wr && hit_evt_ie;
  wire sel_err_flag = bus_i.wr && hit_err_flag;
  wire sel_evt_stat = bus_i.wr && hit_evt_stat;

  // Error enables keep only implemented bits
  wire [7:0] err_ie_wval = bus_i.wdata & ERR_MASK; // R1 R2
  assign err_ie_nxt = sel_err_ie ? err_ie_wval : err_ie; // R1 R2

  // Event enables keep only the abort done and overrun bits
  wire [7:0] evt_ie_wval = bus_i.wdata & EVT_MASK; // R3 R4
  assign evt_ie_nxt = sel_evt_ie ? evt_ie_wval : evt_ie; // R3 R4

  // Severe error sources from the sequencer
  wire [7:0] err_set;
  assign err_set[BIT_IA] = evt_i.store_access_err | evt_i.fetch_outside_mem; // R12
  assign err_set[BIT_CMD] = evt_i.cmd_reserved_bits | evt_i.result_format_reserved; // R13
  assign err_set[BIT_EOL] = evt_i.list_end_missing; // R14
  assign err_set[BIT_TRIG] = evt_i.trigger_early; // R15

  // Restart request error is decided by the sequencer and only latched here
  assign err_set[BIT_RSTAR] = evt_i.restart_req_err;

  // Load ready check is live only in restart mode, outside an abort and not on a first restart
  wire alt_list_load_ready_check_live = evt_i.restart_mode && !evt_i.abort_in_progress && !evt_i.alt_list_load_ready_check_suppress; // R16
  // A restart that finds the alternative list not ready is a load ready error
  wire alt_list_load_ready_miss = evt_i.restart_event && !evt_i.alt_list_load_ready; // R16
  assign err_set[BIT_ALT_LIST_LOAD_READY] = alt_list_load_ready_check_live && alt_list_load_ready_miss; // R16

  // Unimplemented flag positions never set
  assign err_set[BIT_RSVD_HI] = 1'b0;
  assign err_set[BIT_RSVD_LO] = 1'b0;

  // Write one clears only the soft flags; severe flags ignore bus writes
  wire [7:0] err_wclr = sel_err_flag ? (bus_i.wdata & SOFT_MASK) : ZERO8; // R8 R10 R11
  // Soft reset clears every implemented flag, severe and soft alike
  wire [7:0] err_sclr = soft_reset_i ? ERR_MASK : ZERO8; // R6 R8

  // Flags kept after a clear, then new events on top, so a set wins over a clear
  wire [7:0] err_flag_kept = err_flag & ~err_wclr; // R10
  wire [7:0] err_flag_run = (err_flag_kept | err_set) & ERR_MASK; // R10
  // Soft reset drops the flags and any event of the same cycle
  wire [7:0] err_flag_sr = err_flag & ~err_sclr; // R6

  // Disable wins over soft reset, which wins over normal running
  assign err_flag_nxt = !conv_enable_i ? ZERO8 : soft_reset_i ? err_flag_sr : err_flag_run; // R9

  // Event status sources, one bit per event, the rest held zero
  wire [7:0] evt_set;
  assign evt_set[BIT_SEQAD] = abort_done_i; // R3
  assign evt_set[BIT_OVR] = complete_flag_overrun_i; // R4
  assign evt_set[BIT_OVR-1:0] = '0;

  // Write one clears an event status bit, a new event wins
  wire [7:0] evt_wclr = sel_evt_stat ? (bus_i.wdata & EVT_MASK) : ZERO8;
  wire [7:0] evt_stat_run = ((evt_stat_r & ~evt_wclr) | evt_set) & EVT_MASK;

  // Disable and soft reset both empty the event status
  assign evt_stat_nxt = (!conv_enable_i || soft_reset_i) ? ZERO8 : evt_stat_run;

  // Each mapped register offers its value when addressed
  wire [7:0] rd_err_ie = hit_err_ie ? err_ie : ZERO8;
  wire [7:0] rd_evt_ie = hit_evt_ie ? evt_ie : ZERO8;
  wire [7:0] rd_err_flag = hit_err_flag ? err_flag : ZERO8;
  wire [7:0] rd_evt_stat = hit_evt_stat ? evt_stat_r : ZERO8;
  // Hits are exclusive, so an OR merges them; unmapped addresses read zero
  wire [7:0] rd_any = rd_err_ie | rd_evt_ie | rd_err_flag | rd_evt_stat;
  // Read data is zero outside a read so it stands for one cycle only
  assign rdata_nxt = bus_i.rd ? rd_any : ZERO8;

  // Halt only on severe flags; soft flags let the converter run
  assign halt_nxt = |(err_flag_nxt & SEVERE_MASK); // R5 R7
  // Error interrupt pairs each flag with its enable
  assign err_irq_nxt = |(err_flag_nxt & err_ie_nxt); // R17
  // Event interrupt pairs each status bit with its enable
  assign evt_irq_nxt = |(evt_stat_nxt & evt_ie_nxt); // R3 R4

  // Illegal access error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      illegal_access_err_enable_r <= 1'b0;
    end
    else
    begin
      illegal_access_err_enable_r <= err_ie_nxt[BIT_IA]; // R1
    end
  end

  // Bad command error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bad_command_err_enable_r <= 1'b0;
    end
    else
    begin
      bad_command_err_enable_r <= err_ie_nxt[BIT_CMD]; // R1
    end
  end

  // List end error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      list_end_err_enable_r <= 1'b0;
    end
    else
    begin
      list_end_err_enable_r <= err_ie_nxt[BIT_EOL]; // R1
    end
  end

  // Trigger error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trigger_err_enable_r <= 1'b0;
    end
    else
    begin
      trigger_err_enable_r <= err_ie_nxt[BIT_TRIG]; // R2
    end
  end

  // Restart request error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      restart_request_err_enable_r <= 1'b0;
    end
    else
    begin
      restart_request_err_enable_r <= err_ie_nxt[BIT_RSTAR]; // R2
    end
  end

  // Load ready error enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      load_ready_err_enable_r <= 1'b0;
    end
    else
    begin
      load_ready_err_enable_r <= err_ie_nxt[BIT_ALT_LIST_LOAD_READY]; // R2
    end
  end

  // Abort done interrupt enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      abort_done_irq_enable_r <= 1'b0;
    end
    else
    begin
      abort_done_irq_enable_r <= evt_ie_nxt[BIT_SEQAD]; // R3
    end
  end

  // Complete flag overrun interrupt enable bit
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      complete_flag_overrun_enable_r <= 1'b0;
    end
    else
    begin
      complete_flag_overrun_enable_r <= evt_ie_nxt[BIT_OVR]; // R4
    end
  end

  // Illegal access error flag, severe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      illegal_access_err_flag_r <= 1'b0;
    end
    else
    begin
      illegal_access_err_flag_r <= err_flag_nxt[BIT_IA]; // R12
    end
  end

  // Bad command error flag, severe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bad_command_err_flag_r <= 1'b0;
    end
    else
    begin
      bad_command_err_flag_r <= err_flag_nxt[BIT_CMD]; // R13
    end
  end

  // List end error flag, severe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      list_end_err_flag_r <= 1'b0;
    end
    else
    begin
      list_end_err_flag_r <= err_flag_nxt[BIT_EOL]; // R14
    end
  end

  // Trigger error flag, severe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trigger_err_flag_r <= 1'b0;
    end
    else
    begin
      trigger_err_flag_r <= err_flag_nxt[BIT_TRIG]; // R15
    end
  end

  // Restart request error flag, soft
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      restart_request_err_flag_r <= 1'b0;
    end
    else
    begin
      restart_request_err_flag_r <= err_flag_nxt[BIT_RSTAR]; // R8
    end
  end

  // Load ready error flag, soft
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      load_ready_err_flag_r <= 1'b0;
    end
    else
    begin
      load_ready_err_flag_r <= err_flag_nxt[BIT_ALT_LIST_LOAD_READY]; // R16
    end
  end

  // Sticky event status register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      evt_stat_r <= ZERO8;
    end
    else
    begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= ZERO8;
      conv_halt_o <= 1'b0;
      err_irq_o <= 1'b0;
      evt_irq_o <= 1'b0;
    end
    else
    begin
      rdata_o <= rdata_nxt;
      conv_halt_o <= halt_nxt;
      err_irq_o <= err_irq_nxt;
      evt_irq_o <= evt_irq_nxt;
    end
  end
endmodule // adceil_top

/* File: logic/adceil_pkg.sv */
// Summary of operation
// R1: Error interrupt enable bits 7, 6 and 5 enable the illegal access, bad command and list end interrupts.
// R2: Error interrupt enable bits 3, 2 and 1 enable the trigger, restart request and load ready interrupts.
// R3: Event interrupt enable bit 7 enables the abort done interrupt.
// R4: Event interrupt enable bit 6 enables the complete flag overrun interrupt.
// R5: Any set severe flag (illegal access, bad command, list end, trigger) stops the converter.
// R6: Only a converter soft reset resumes operation after a severe error, and it clears the four severe flags; the code also clears them on a low enable.
// R7: The restart request and load ready flags do not stop the converter.
// R8: Writing one clears the restart request or load ready flag, and a soft reset clears both.
// R9: All error flags are held clear while the converter enable is low.
// R10: Writing zero leaves a flag alone and writing one never sets a flag.
// R11: Software writes to the four severe flags are ignored.
// R12: Bit 7 is set on a result store access error or a command fetch from outside RAM or NVM.
// R13: Bit 6 is set when a loaded command holds reserved bits or a reserved result format.
// R14: Bit 5 is set when the executed command list lacks an end of list command.
// R15: Bit 3 is set when a trigger arrives before the current sequence has finished.
// R16: In restart mode bit 1 is set when a restart arrives without the alternative list load ready.
// R17: The error interrupt is high while any error flag and its enable are both set.
package adceil_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_ERR_IE = 4'h6;
  localparam logic [3:0] OFS_EVT_IE = 4'h7;
  localparam logic [3:0] OFS_ERR_FLAG = 4'h8;
  localparam logic [3:0] OFS_EVT_STAT = 4'h9;
  localparam int BIT_IA = 7;
  localparam int BIT_CMD = 6;
  localparam int BIT_EOL = 5;
  localparam int BIT_TRIG = 3;
  localparam int BIT_RSTAR = 2;
  localparam int BIT_ALT_LIST_LOAD_READY = 1;
  localparam int BIT_RSVD_HI = 4;
  localparam int BIT_RSVD_LO = 0;
  localparam int BIT_SEQAD = 7;
  localparam int BIT_OVR = 6;
  localparam logic [7:0] ERR_MASK = 8'hEE;
  localparam logic [7:0] SEVERE_MASK = 8'hE8;
  localparam logic [7:0] SOFT_MASK = 8'h06;
  localparam logic [7:0] EVT_MASK = 8'hC0;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Hardware error events from the sequencer, one cycle pulses
  typedef struct packed {
    logic store_access_err;
    logic fetch_outside_mem;
    logic cmd_reserved_bits;
    logic result_format_reserved;
    logic list_end_missing;
    logic trigger_early;
    logic restart_req_err;
    logic restart_event;
    logic alt_list_load_ready;
    logic restart_mode;
    logic abort_in_progress;
    logic alt_list_load_ready_check_suppress;
  } adceil_evt_t;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adceil_bus_t;
endpackage

/* File: dv/adceil_checker.sv */
`timescale 1ns/10ps
module adceil_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic conv_enable_i,
  input wire logic soft_reset_i,
  input wire adceil_pkg::adceil_evt_t evt_i,
  input wire logic abort_done_i,
  input wire logic complete_flag_overrun_i,
  input wire adceil_pkg::adceil_bus_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic conv_halt_o,
  input wire logic err_irq_o,
  input wire logic evt_irq_o
);
  import adceil_pkg::*;
  // Flags may change, and a severe event is present
  wire ok = conv_enable_i && !soft_reset_i;
  wire sev = |evt_i[11:6];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_off; !conv_enable_i ##1 (bus_i.rd && bus_i.addr == OFS_ERR_FLAG); endsequence
  property p_sev; ok && sev |=> conv_halt_o; endproperty
  property p_ia; ok && evt_i.fetch_outside_mem |=> conv_halt_o; endproperty
  property p_keep; ok && conv_halt_o |=> conv_halt_o; endproperty
  property p_soft; !conv_halt_o && !sev |=> !conv_halt_o; endproperty
  property p_sr; soft_reset_i |=> !conv_halt_o && !err_irq_o && !evt_irq_o; endproperty
  property p_dis; !conv_enable_i |=> !conv_halt_o && !err_irq_o && !evt_irq_o; endproperty
  property p_off; s_off |=> rdata_o == ZERO8; endproperty
  property p_irq; $rose(err_irq_o) |-> $past(sev || evt_i.restart_req_err || evt_i.restart_event || bus_i.wr);
  endproperty
  a_sev: assert property (p_sev) else $error("no halt");
  a_ia: assert property (p_ia) else $error("no halt");
  a_keep: assert property (p_keep) else $error("halt lost");
  a_soft: assert property (p_soft) else $error("bad halt");
  a_sr: assert property (p_sr) else $error("not cleared");
  a_dis: assert property (p_dis) else $error("not cleared");
  a_off: assert property (p_off) else $error("flags kept");
  a_irq: assert property (p_irq) else $error("bad irq");
endmodule // adceil_checker

/* File: dv/adceil_top_tb.sv */
`timescale 1ns/10ps
module adceil_top_tb;
  import adceil_pkg::*;
  logic clk_i = 0, rst_b_i = 0, conv_enable_i = 0, soft_reset_i = 0, abort_done_i = 0, complete_flag_overrun_i = 0;
  adceil_evt_t evt_i = '0;
  adceil_bus_t bus_i = '0;
  logic [7:0] rdata_o;
  logic conv_halt_o, err_irq_o, evt_irq_o;
  int bad_count = 0, n_checks = 0, cyc = 0;
  // Rows: event, error enable, expected flags
  logic [27:0] rows [11] = '{28'h800_8080, 28'h400_6E80, 28'h200_4040, 28'h100_AE40, 28'h080_2020, 28'h040_0808,
    28'h020_EA04, 28'h014_0202, 28'h01C_EE00, 28'h016_EE00, 28'h015_EE00};
  adceil_top adceil_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_enable_i(conv_enable_i), .soft_reset_i(soft_reset_i),
    .evt_i(evt_i), .abort_done_i(abort_done_i), .complete_flag_overrun_i(complete_flag_overrun_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .conv_halt_o(conv_halt_o), .err_irq_o(err_irq_o), .evt_irq_o(evt_irq_o));
  // Clock and hang limit
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc == 3000) print_verdict(1);
  task chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) bus_i <= '0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i) bus_i <= '0;
    #1 chk(rdata_o, e);
  endtask
  task ev(input adceil_evt_t v, input logic a, input logic s);
    @(posedge clk_i) evt_i <= v;
    abort_done_i <= a;
    complete_flag_overrun_i <= a;
    soft_reset_i <= s;
    @(posedge clk_i) {evt_i, abort_done_i, complete_flag_overrun_i, soft_reset_i} <= '0;
    #1;
  endtask
  task print_verdict(input int extra);
    bad_count += extra;
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset, table of events, then hand cases
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1;
    conv_enable_i <= 1;
    rd(OFS_ERR_IE, ZERO8);
    rd(OFS_EVT_IE, ZERO8);
    rd(4'hF, ZERO8);
    foreach (rows[i])
    begin
      wr(OFS_ERR_IE, rows[i][15:8]);
      rd(OFS_ERR_IE, rows[i][15:8]);
      ev(rows[i][27:16], 0, 0);
      chk(8'(conv_halt_o), 8'(|(rows[i][7:0] & SEVERE_MASK)));
      chk(8'(err_irq_o), 8'(|(rows[i][7:0] & rows[i][15:8])));
      rd(OFS_ERR_FLAG, rows[i][7:0]);
      ev('0, 0, 1);
    end
    ev(12'h060, 0, 0);
    wr(OFS_ERR_FLAG, ZERO8);
    rd(OFS_ERR_FLAG, 8'h0C);
    wr(OFS_ERR_FLAG, 8'hFF);
    rd(OFS_ERR_FLAG, 8'h08);
    ev('0, 0, 1);
    rd(OFS_ERR_FLAG, ZERO8);
    // A set in the same cycle as a write-one clear wins
    @(posedge clk_i)
    begin
      bus_i <= '{OFS_ERR_FLAG, 8'h04, 1'b1, 1'b0};
      evt_i <= 12'h020;
    end
    @(posedge clk_i)
    begin
      bus_i <= '0;
      evt_i <= '0;
    end
    rd(OFS_ERR_FLAG, 8'h04);
    ev(12'h800, 0, 0);
    @(posedge clk_i) conv_enable_i <= 0;
    ev(12'h800, 0, 0);
    rd(OFS_ERR_FLAG, ZERO8);
    @(posedge clk_i) conv_enable_i <= 1;
    wr(OFS_EVT_IE, 8'h80);
    ev('0, 1, 0);
    chk(8'(evt_irq_o), 8'h01);
    rd(OFS_EVT_STAT, 8'hC0);
    wr(OFS_EVT_STAT, 8'h80);
    chk(8'(evt_irq_o), 8'h00);
    wr(OFS_EVT_IE, 8'h40);
    chk(8'(evt_irq_o), 8'h01);
    print_verdict(0);
  end
endmodule // adceil_top_tb
bind adceil_top adceil_checker adceil_checker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_enable_i(conv_enable_i),
  .soft_reset_i(soft_reset_i), .evt_i(evt_i), .abort_done_i(abort_done_i), .complete_flag_overrun_i(complete_flag_overrun_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .conv_halt_o(conv_halt_o), .err_irq_o(err_irq_o), .evt_irq_o(evt_irq_o));
